// file: pcg_consts.svh
// Purpose: Offsets, field positions and reset values of the socket-1 pin gating block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
//
// Operation
// - Drive enable low tri-states the card reset output.
// - Enabled and sleeping: reset tri-stated if sleep drive low, else driven low.
// - Enabled and awake: card reset follows the reset control bit.
// - Address bus tri-stated when any card detect is high or drive enable low.
// - Detected, enabled, sleeping: address tri-stated or driven low per sleep drive.
// - Awake: address low if socket select or both enables high, else internal address.
// - Data bus is bidirectional, 16 bits, byte or word transfers only.
// - Drive enable low keeps the data outputs tri-stated.
// - Enabled and sleeping: data tri-stated or driven low per sleep drive bit.
// - Awake: data tri-stated during read or output strobe with select low.
// - Awake: attribute select passes internal select only if detected and select low.
// - Enabled and sleeping: attribute select tri-stated or forced high per sleep drive.
// - Drive enable low tri-states the attribute select output.
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

`define PCG_ADDR_W          12
`define PCG_OFF_CTRL        12'h000
`define PCG_OFF_SLEEP_STATE 12'h004
`define PCG_OFF_PM          12'h008
`define PCG_OFF_STATUS      12'h00C

`define PCG_CTRL_RESET_BIT  1
`define PCG_CTRL_DRIVE_BIT  3
`define PCG_SLEEP_DRIVE_BIT 1
`define PCG_PM_SLEEP_BIT    0

`define PCG_CTRL_RST        4'h0
`define PCG_SLEEP_STATE_RST 2'h0
`define PCG_PM_RST          1'h0

`define PCG_ADDR_BITS       11
`define PCG_DATA_BITS       16
`define PCG_BYTE_BITS       8
`define PCG_SYNC_BITS       18

`endif

// file: pcg_pkg.sv
// Purpose: Types of the socket-1 pin gating block
// Assumes: Constants header supplies widths
// Notes:   No imports anywhere
`default_nettype none
`include "pcg_consts.svh"
package pcg_pkg;

    typedef struct packed {
        logic                        reset_val;
        logic                        reset_oe;
        logic [`PCG_ADDR_BITS-1:0]   addr_val;
        logic                        addr_oe;
        logic [`PCG_DATA_BITS-1:0]   data_val;
        logic                        data_oe;
        logic                        attr_n_val;
        logic                        attr_oe;
    } pcg_pins_t;

    typedef struct packed {
        logic [1:0]                  card_detect_n;
        logic [`PCG_DATA_BITS-1:0]   data_in;
    } pcg_sync_t;

    typedef struct packed {
        pcg_sync_t                   stage1;
        pcg_sync_t                   stage2;
    } pcg_sync_state_t;

    typedef struct packed {
        logic [3:0]                  ctrl;
        logic [1:0]                  sleep_state;
        logic                        sleep;
        logic                        pready;
        logic                        pslverr;
        logic [31:0]                 prdata;
        pcg_pins_t                   pins;
        logic [`PCG_DATA_BITS-1:0]   rd_data;
    } pcg_state_t;

endpackage
`default_nettype wire

// file: pcg_sync.sv
// Purpose: Two-stage synchroniser for socket-1 pin inputs
// Assumes: Inputs are asynchronous to pclk
// Notes:   First stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
`include "pcg_consts.svh"
module pcg_sync (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Raw pins
    input  wire pcg_pkg::pcg_sync_t raw,
    // Synchronised
    output var  pcg_pkg::pcg_sync_t synced
);

    pcg_pkg::pcg_sync_state_t st;
    pcg_pkg::pcg_sync_state_t next_st;

    always_comb begin
        next_st.stage1 = raw;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{stage1: '{card_detect_n: 2'h3, data_in: 16'h0000},
                    stage2: '{card_detect_n: 2'h3, data_in: 16'h0000}};
        end else begin
            st <= next_st;
        end
    end

    assign synced = st.stage2;

endmodule // pcg_sync
`default_nettype wire

// file: pcg_socket1_gate.sv
// Purpose: Socket-1 output gating for reset, address, data and attribute select pins
// Assumes: APB slave on pclk; internal card-interface signals on pclk; pins asynchronous
// Notes:   Pin outputs are registered, one pclk behind internal causes, three behind card detect
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "pcg_consts.svh"
module pcg_socket1_gate (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [`PCG_ADDR_W-1:0]      paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Internal card-interface signals
    input  wire logic [`PCG_ADDR_BITS-1:0]   int_addr,
    input  wire logic [`PCG_DATA_BITS-1:0]   int_data_wr,
    input  wire logic                        int_byte_mode,
    input  wire logic [1:0]                  int_card_enable_n,
    input  wire logic                        int_io_read_n,
    input  wire logic                        int_output_enable_n,
    input  wire logic                        int_attr_select_n,
    input  wire logic                        socket_select,
    output logic [`PCG_DATA_BITS-1:0]        int_data_rd,
    output logic                             sleep_active,
    // Socket-1 pins
    input  wire logic [1:0]                  sock1_card_detect_n,
    input  wire logic [`PCG_DATA_BITS-1:0]   sock1_data_bus_in,
    output logic                             sock1_card_reset,
    output logic                             sock1_card_reset_oe,
    output logic [`PCG_ADDR_BITS-1:0]        sock1_addr_bus,
    output logic                             sock1_addr_bus_oe,
    output logic [`PCG_DATA_BITS-1:0]        sock1_data_bus_out,
    output logic                             sock1_data_bus_oe,
    output logic                             sock1_attr_select_n,
    output logic                             sock1_attr_select_oe
);

    pcg_pkg::pcg_state_t st;
    pcg_pkg::pcg_state_t next_st;
    pcg_pkg::pcg_sync_t  raw_pins;
    pcg_pkg::pcg_sync_t  sync_pins;

    assign raw_pins.card_detect_n = sock1_card_detect_n;
    assign raw_pins.data_in       = sock1_data_bus_in;

    // Card detect and data inputs cross in here
    pcg_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     (raw_pins),
        .synced  (sync_pins)
    );

    logic drive_en;
    logic reset_ctl;
    logic sleep_drive;
    logic detected;
    logic setup_ph;
    logic access_ph;
    logic hit_ctrl;
    logic hit_sleep;
    logic hit_pm;
    logic hit_status;
    logic hit_any;
    logic [31:0] read_word;

    // Decode of the register bits and the card detect that steer the pins
    assign drive_en    = st.ctrl[`PCG_CTRL_DRIVE_BIT];
    assign reset_ctl   = st.ctrl[`PCG_CTRL_RESET_BIT];
    assign sleep_drive = st.sleep_state[`PCG_SLEEP_DRIVE_BIT];
    assign detected    = (sync_pins.card_detect_n == 2'h0);

    // APB phases and address decode
    assign setup_ph   = psel && !penable;
    assign access_ph  = psel && penable && st.pready;
    assign hit_ctrl   = (paddr == `PCG_OFF_CTRL);
    assign hit_sleep  = (paddr == `PCG_OFF_SLEEP_STATE);
    assign hit_pm     = (paddr == `PCG_OFF_PM);
    assign hit_status = (paddr == `PCG_OFF_STATUS);
    assign hit_any    = hit_ctrl || hit_sleep || hit_pm || hit_status;

    // Read mux, taken in the setup cycle
    always_comb begin
        read_word = 32'h0000_0000;
        if (hit_ctrl) begin
            read_word[3:0] = st.ctrl;
        end else if (hit_sleep) begin
            read_word[1:0] = st.sleep_state;
        end else if (hit_pm) begin
            read_word[0] = st.sleep;
        end else if (hit_status) begin
            read_word[1:0] = sync_pins.card_detect_n;
            read_word[2]   = detected;
            read_word[3]   = st.pins.reset_oe;
            read_word[4]   = st.pins.addr_oe;
            read_word[5]   = st.pins.data_oe;
            read_word[6]   = st.pins.attr_oe;
            read_word[7]   = st.pins.reset_val;
            read_word[8]   = st.pins.attr_n_val;
        end
    end

    always_comb begin
        next_st = st;

        // Bus slave: ready in the access cycle, one wait-free answer
        next_st.pready  = setup_ph;
        next_st.pslverr = setup_ph && !hit_any;
        if (setup_ph) begin
            next_st.prdata = pwrite ? 32'h0000_0000 : read_word;
        end

        if (access_ph && pwrite) begin
            if (hit_ctrl) begin
                next_st.ctrl = pwdata[3:0];
            end
            if (hit_sleep) begin
                next_st.sleep_state = pwdata[1:0];
            end
            if (hit_pm) begin
                next_st.sleep = pwdata[`PCG_PM_SLEEP_BIT];
            end
        end

        // Card reset
        if (!drive_en) begin
            next_st.pins.reset_oe  = 1'b0;
            next_st.pins.reset_val = 1'b0;
        end else if (st.sleep) begin
            next_st.pins.reset_oe  = sleep_drive;
            next_st.pins.reset_val = 1'b0;
        end else begin
            next_st.pins.reset_oe  = 1'b1;
            next_st.pins.reset_val = reset_ctl;
        end

        // Address bus
        if (!detected || !drive_en) begin
            next_st.pins.addr_oe  = 1'b0;
            next_st.pins.addr_val = 11'h000;
        end else if (st.sleep) begin
            next_st.pins.addr_oe  = sleep_drive;
            next_st.pins.addr_val = 11'h000;
        end else if (socket_select || (int_card_enable_n == 2'h3)) begin
            next_st.pins.addr_oe  = 1'b1;
            next_st.pins.addr_val = 11'h000;
        end else begin
            next_st.pins.addr_oe  = 1'b1;
            next_st.pins.addr_val = int_addr;
        end

        // Data bus
        if (!drive_en) begin
            next_st.pins.data_oe  = 1'b0;
            next_st.pins.data_val = 16'h0000;
        end else if (st.sleep) begin
            next_st.pins.data_oe  = sleep_drive;
            next_st.pins.data_val = 16'h0000;
        end else if ((!int_io_read_n || !int_output_enable_n) && !socket_select) begin
            next_st.pins.data_oe  = 1'b0;
            next_st.pins.data_val = 16'h0000;
        end else begin
            next_st.pins.data_oe  = 1'b1;
            next_st.pins.data_val = int_byte_mode
                                  ? {8'h00, int_data_wr[`PCG_BYTE_BITS-1:0]}
                                  : int_data_wr;
        end

        // Read path back to the processor, byte or word only
        next_st.rd_data = int_byte_mode
                        ? {8'h00, sync_pins.data_in[`PCG_BYTE_BITS-1:0]}
                        : sync_pins.data_in;

        // Attribute memory select
        if (!drive_en) begin
            next_st.pins.attr_oe    = 1'b0;
            next_st.pins.attr_n_val = 1'b1;
        end else if (st.sleep) begin
            next_st.pins.attr_oe    = sleep_drive;
            next_st.pins.attr_n_val = 1'b1;
        end else if (detected && !socket_select) begin
            next_st.pins.attr_oe    = 1'b1;
            next_st.pins.attr_n_val = int_attr_select_n;
        end else begin
            next_st.pins.attr_oe    = 1'b1;
            next_st.pins.attr_n_val = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.ctrl             <= `PCG_CTRL_RST;
            st.sleep_state      <= `PCG_SLEEP_STATE_RST;
            st.sleep            <= `PCG_PM_RST;
            st.pready           <= 1'b0;
            st.pslverr          <= 1'b0;
            st.prdata           <= 32'h0000_0000;
            st.pins.reset_val   <= 1'b0;
            st.pins.reset_oe    <= 1'b0;
            st.pins.addr_val    <= 11'h000;
            st.pins.addr_oe     <= 1'b0;
            st.pins.data_val    <= 16'h0000;
            st.pins.data_oe     <= 1'b0;
            st.pins.attr_n_val  <= 1'b1;
            st.pins.attr_oe     <= 1'b0;
            st.rd_data          <= 16'h0000;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign prdata               = st.prdata;
    assign pready               = st.pready;
    assign pslverr              = st.pslverr;
    assign int_data_rd          = st.rd_data;
    assign sleep_active         = st.sleep;
    assign sock1_card_reset     = st.pins.reset_val;
    assign sock1_card_reset_oe  = st.pins.reset_oe;
    assign sock1_addr_bus       = st.pins.addr_val;
    assign sock1_addr_bus_oe    = st.pins.addr_oe;
    assign sock1_data_bus_out   = st.pins.data_val;
    assign sock1_data_bus_oe    = st.pins.data_oe;
    assign sock1_attr_select_n  = st.pins.attr_n_val;
    assign sock1_attr_select_oe = st.pins.attr_oe;

endmodule // pcg_socket1_gate
`default_nettype wire

// file: pcg_card.sv
// Purpose: PC Card model standing in the socket
// Assumes: Card drives data whenever it is inserted and the device lets go
// Notes:   Absent card leaves a floating, changing bus
`timescale 1ns/1ns
`default_nettype none
module pcg_card (
    // Clock and presence
    input  wire logic        pclk,
    input  wire logic        inserted,
    // Socket pins
    input  wire logic [10:0] addr,
    input  wire logic [15:0] dev_data,
    input  wire logic        dev_oe,
    output logic [1:0]       card_detect_n,
    output logic [15:0]      data_bus
);
    logic [15:0] noise = 16'hAAAA;
    always @(posedge pclk) begin
        noise <= ~noise;
    end
    assign card_detect_n = inserted ? 2'b00 : 2'b11;
    // Card answers with a value tied to the address
    assign data_bus = dev_oe ? dev_data : (inserted ? {~addr[7:0], addr[7:0]} : noise);
endmodule // pcg_card
`default_nettype wire

// file: pcg_socket1_gate_monitor.sv
// Purpose: Port-level checks of socket-1 pin gating
// Assumes: Pins lag their causes by one pclk, detect by three
// Notes:   Bound to the top module
`timescale 1ns/1ns
`default_nettype none
`include "pcg_consts.svh"
module pcg_socket1_gate_monitor (
    // Clock, reset, bus
    input wire logic pclk, presetn, psel, penable, pready,
    // Internal signals
    input wire logic [`PCG_ADDR_BITS-1:0] int_addr,
    input wire logic [1:0] int_card_enable_n,
    input wire logic int_io_read_n, int_output_enable_n, int_attr_select_n, socket_select,
    input wire logic sleep_active,
    // Pins
    input wire logic [1:0] sock1_card_detect_n,
    input wire logic sock1_card_reset, sock1_card_reset_oe,
    input wire logic [`PCG_ADDR_BITS-1:0] sock1_addr_bus,
    input wire logic sock1_addr_bus_oe,
    input wire logic [`PCG_DATA_BITS-1:0] sock1_data_bus_out,
    input wire logic sock1_data_bus_oe, sock1_attr_select_n, sock1_attr_select_oe
);
    logic asleep;
    logic awake;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) asleep <= 1'b0;
        else asleep <= sleep_active;
    end
    assign awake = !asleep && !sleep_active;
    a_bus_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    a_sleep_reset_low: assert property (asleep && sleep_active && sock1_card_reset_oe |-> !sock1_card_reset)
        else $error("card reset not low in sleep");
    a_sleep_addr_low: assert property (asleep && sleep_active && sock1_addr_bus_oe |-> sock1_addr_bus == 11'h000)
        else $error("address not low in sleep");
    a_sleep_data_low: assert property (asleep && sleep_active && sock1_data_bus_oe |-> sock1_data_bus_out == 16'h0000)
        else $error("data not low in sleep");
    a_sleep_attr_high: assert property (asleep && sleep_active && sock1_attr_select_oe |-> sock1_attr_select_n)
        else $error("attribute select not high in sleep");
    a_addr_needs_detect: assert property (sock1_addr_bus_oe |-> $past(sock1_card_detect_n, 3) == 2'b00)
        else $error("address driven without card");
    a_addr_awake_path: assert property (awake && sock1_addr_bus_oe |-> sock1_addr_bus == (($past(socket_select) || $past(int_card_enable_n) == 2'b11) ? 11'h000 : $past(int_addr)))
        else $error("address path wrong");
    a_data_read_float: assert property (awake && (!$past(int_io_read_n) || !$past(int_output_enable_n)) && !$past(socket_select) |-> !sock1_data_bus_oe)
        else $error("data driven during read");
    a_attr_awake_path: assert property (awake && sock1_attr_select_oe |-> sock1_attr_select_n == (($past(sock1_card_detect_n, 3) == 2'b00 && !$past(socket_select)) ? $past(int_attr_select_n) : 1'b1))
        else $error("attribute select path wrong");
endmodule // pcg_socket1_gate_monitor
bind pcg_socket1_gate pcg_socket1_gate_monitor mon_u (.pclk, .presetn, .psel, .penable, .pready,
    .int_addr, .int_card_enable_n, .int_io_read_n, .int_output_enable_n, .int_attr_select_n,
    .socket_select, .sleep_active, .sock1_card_detect_n, .sock1_card_reset, .sock1_card_reset_oe,
    .sock1_addr_bus, .sock1_addr_bus_oe, .sock1_data_bus_out, .sock1_data_bus_oe,
    .sock1_attr_select_n, .sock1_attr_select_oe);
`default_nettype wire

// file: test_pc_card_socket1_pin_gating.sv
// Purpose: Self-checking bench for socket-1 pin gating
// Assumes: Zero-wait APB slave, card model on the pins
// Notes:   Pin checks wait five edges for the sync path
`timescale 1ns/1ns
`default_nettype none
`include "pcg_consts.svh"
module test_pc_card_socket1_pin_gating;
    logic                   pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [`PCG_ADDR_W-1:0] paddr = 12'h000;
    logic [31:0]            pwdata = 32'h0, prdata, rd;
    logic                   pready, pslverr, err, inserted = 1'b1, byte_mode = 1'b0;
    logic [10:0]            int_addr = 11'h5A3, addr_v;
    logic [15:0]            int_data_wr = 16'hC3A5, int_data_rd, bus_in, bus_out;
    logic                   io_rd_n = 1'b1, oe_n = 1'b1, attr_n = 1'b0, sock_sel = 1'b0;
    logic [1:0]             ce_n = 2'b10, cd_n;
    logic                   sleep_active, rst_v, rst_oe, addr_oe, data_oe, attr_v, attr_oe;
    int                     num_errors = 0, num_checks = 0, cycles = 0;
    wire  [32:0]            pins = {rst_oe, rst_v, addr_oe, addr_v, data_oe, bus_out, attr_oe, attr_v};
    wire  [3:0]             oes = {rst_oe, addr_oe, data_oe, attr_oe};
    pcg_socket1_gate dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .int_addr, .int_data_wr, .int_byte_mode(byte_mode),
        .int_card_enable_n(ce_n), .int_io_read_n(io_rd_n), .int_output_enable_n(oe_n),
        .int_attr_select_n(attr_n), .socket_select(sock_sel), .int_data_rd, .sleep_active,
        .sock1_card_detect_n(cd_n), .sock1_data_bus_in(bus_in), .sock1_card_reset(rst_v),
        .sock1_card_reset_oe(rst_oe), .sock1_addr_bus(addr_v), .sock1_addr_bus_oe(addr_oe),
        .sock1_data_bus_out(bus_out), .sock1_data_bus_oe(data_oe),
        .sock1_attr_select_n(attr_v), .sock1_attr_select_oe(attr_oe));
    pcg_card card_u (.pclk, .inserted, .addr(addr_v), .dev_data(bus_out), .dev_oe(data_oe),
        .card_detect_n(cd_n), .data_bus(bus_in));
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            print_verdict();
        end
    end
    function automatic logic [32:0] pv(input logic [5:0] f, input logic [10:0] a, input logic [15:0] d);
        return {f[5], f[4], f[3], a, f[2], d, f[1], f[0]};
    endfunction
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle;
        repeat (5) @(posedge pclk);
    endtask
    task automatic t_regs;
        check("pins at reset", pins, pv(6'b000001, 11'h000, 16'h0000));
        apb(1'b1, `PCG_OFF_CTRL, 32'hFFFFFFFF);
        apb(1'b0, `PCG_OFF_CTRL, 32'h0);
        check("ctrl width", rd, 32'h0000000F);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped", {err, rd}, {1'b1, 32'h00000000});
    endtask
    task automatic t_awake;
        apb(1'b1, `PCG_OFF_CTRL, 32'h8);
        settle();
        check("awake pins", pins, pv(6'b101110, 11'h5A3, 16'hC3A5));
        apb(1'b1, `PCG_OFF_CTRL, 32'hA);
        settle();
        check("reset follows", rst_v, 1'b1);
        ce_n <= 2'b11;
        settle();
        check("enables high", addr_v, 11'h000);
        ce_n <= 2'b10;
        sock_sel <= 1'b1;
        io_rd_n <= 1'b0;
        settle();
        check("select high", {addr_v, attr_v, data_oe}, {11'h000, 1'b1, 1'b1});
        sock_sel <= 1'b0;
        settle();
        check("io read", data_oe, 1'b0);
        check("card word", int_data_rd, 16'h5CA3);
        byte_mode <= 1'b1;
        settle();
        check("card byte", int_data_rd, 16'h00A3);
        byte_mode <= 1'b0;
        io_rd_n <= 1'b1;
        oe_n <= 1'b0;
        settle();
        check("output strobe", data_oe, 1'b0);
        oe_n <= 1'b1;
        inserted <= 1'b0;
        settle();
        check("no card", {addr_oe, attr_v}, {1'b0, 1'b1});
        inserted <= 1'b1;
        byte_mode <= 1'b1;
        settle();
        check("byte out", {data_oe, bus_out}, {1'b1, 16'h00A5});
        byte_mode <= 1'b0;
    endtask
    task automatic t_sleep;
        apb(1'b1, `PCG_OFF_PM, 32'h1);
        apb(1'b1, `PCG_OFF_SLEEP_STATE, 32'h0);
        settle();
        check("sleep float", oes, 4'h0);
        check("sleep flag", sleep_active, 1'b1);
        apb(1'b1, `PCG_OFF_SLEEP_STATE, 32'h2);
        settle();
        check("sleep driven", pins, pv(6'b101111, 11'h000, 16'h0000));
        apb(1'b0, `PCG_OFF_STATUS, 32'h0);
        check("status word", rd, 32'h0000017C);
        apb(1'b0, `PCG_OFF_PM, 32'h0);
        check("sleep bit", rd, 32'h00000001);
    endtask
    task automatic t_off;
        apb(1'b1, `PCG_OFF_PM, 32'h0);
        apb(1'b1, `PCG_OFF_CTRL, 32'h2);
        settle();
        check("disabled", {oes, sleep_active}, 5'h00);
    endtask
    task automatic print_verdict;
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_awake();
        t_sleep();
        t_off();
        print_verdict();
    end
endmodule // test_pc_card_socket1_pin_gating
`default_nettype wire
